// File: pkg/sld_pkg.sv
// shared constants of the supply level detector control
package sld_pkg;
    // register indices on the plain port
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] STAT_OFF = 4'h1;
    localparam logic [3:0] IRQS_OFF = 4'h2;
    localparam logic [3:0] IRQM_OFF = 4'h3;
    // control register fields
    localparam int RANGE_BIT = 3;
    localparam int TRIM_LSB  = 0;
    localparam int TRIM_W    = 3;
    // status register fields
    localparam int EN_BIT    = 0;
    localparam int VALID_BIT = 1;
    localparam int RES_BIT   = 2;
    // interrupt bit, same place as in the mid interrupt register
    localparam int IRQ_BIT   = 2;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] IRQ_RST  = 8'h00;
    // timing
    localparam int CLK_MHZ     = 200;
    localparam int SETTLE_US   = 2000;
    localparam int PULSE_US    = 875;
    localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
    localparam int PULSE_CYC   = PULSE_US * CLK_MHZ;
    // detector sequence
    typedef enum logic [1:0] {
        ST_OFF    = 2'b00,
        ST_SETTLE = 2'b01,
        ST_ACTIVE = 2'b10
    } sld_state_e;
endpackage

// File: src/sld_pulse_filter.sv
// dip filter: output high once sample held COUNT cycles
`timescale 1ns/1ps
`default_nettype none
module sld_pulse_filter #(
    parameter int COUNT = 175000
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic enable,
    input  wire logic sample,
    output logic      stable_ff
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt_ff;

    // shorter dips are ignored as noise
    always_ff @(posedge clock) begin
        if (sys_rst || !enable || !sample) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LAST) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    // drops at once when supply recovers
    always_ff @(posedge clock) begin
        if (sys_rst || !enable || !sample) begin
            stable_ff <= 1'b0;
        end else if (cnt_ff == LAST) begin
            stable_ff <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: src/sld_settle_timer.sv
// settling timer: pulses done once in the COUNT-th cycle of run
`timescale 1ns/1ps
`default_nettype none
module sld_settle_timer #(
    parameter int COUNT = 400000
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic run,
    output logic      done_ff
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt_ff;

    // restarts from zero whenever run drops
    always_ff @(posedge clock) begin
        if (sys_rst || !run) begin
            cnt_ff <= '0;
        end else if (cnt_ff != LAST) begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    // one-cycle pulse on the last count
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= run && (cnt_ff == LAST - W'(1));
        end
    end
endmodule
`default_nettype wire

// File: src/sld_top.sv
// supply level detector control, status and interrupt
//
// Behaviour
// - enable bit 1 powers the detector on, 0 powers it off
// - while disabled the analog detector stays powered down
// - writing enable as 1 alone starts a measurement
// - after valid and while enabled, low supply raises maskable irq
// - each 0 to 1 step of the result gives one irq event
// - status bit 2 is the read-only below-threshold result, reset 0
// - status bit 1 is the read-only valid flag, reset 0
// - control bit 3 selects range, reset 0; 1 is 2.55 V
// - control bits 2:0 are the eight-step trim, reset 000
// - the irq sits at bit 2 of the mid interrupt register
// - dips shorter than the minimum pulse width go undetected
//
// register map on the plain port
//   index 0 control: bit 3 range, bits 2:0 trim, bits 7:4 reserved
//   index 1 status: bit 2 result, bit 1 valid, bit 0 enable
//   index 2 irq status: bit 2 set on a result rise, write 1 clears
//   index 3 irq mask: bit 2 only, other bits read 0
//   indices 4 to 15 read 0 and ignore writes
//
// timing
//   settling counts SETTLE_CYC cycles from the first powered cycle
//   a dip must hold PULSE_CYC cycles before the result may rise
//   valid reaches software a few cycles past the settling count
//
// limitations
//   trim and range only leave on pins; the analog threshold is outside
//   the result stays low until valid, so no event fires while settling
//   a disable drops valid and result on the very next cycle
//   the level interrupt lags the sticky bit by one cycle
`timescale 1ns/1ps
`default_nettype none
module sld_top #(
    parameter int SETTLE_CYC = sld_pkg::SETTLE_CYC,
    parameter int PULSE_CYC  = sld_pkg::PULSE_CYC
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       comp_below,
    output logic            detector_power_en,
    output logic            range_select,
    output logic      [2:0] threshold_trim,
    output logic            low_supply_irq
);
    // address match, shared by the write and read paths
    function automatic logic hit(
        input logic [3:0] a,
        input logic [3:0] off
    );
        hit = (a == off);
    endfunction

    // read word of the control register, reserved bits as zero
    function automatic logic [7:0] ctrl_word(
        input logic       rng,
        input logic [2:0] trm
    );
        ctrl_word                                            = 8'h00;
        ctrl_word[sld_pkg::RANGE_BIT]                        = rng;
        ctrl_word[sld_pkg::TRIM_LSB +: sld_pkg::TRIM_W]      = trm;
    endfunction

    // read word of the status register, reserved bits as zero
    function automatic logic [7:0] stat_word(
        input logic en,
        input logic vld,
        input logic res
    );
        stat_word                     = 8'h00;
        stat_word[sld_pkg::EN_BIT]    = en;
        stat_word[sld_pkg::VALID_BIT] = vld;
        stat_word[sld_pkg::RES_BIT]   = res;
    endfunction

    // detector sequence
    sld_pkg::sld_state_e state_ff;
    sld_pkg::sld_state_e nxt_state;

    // software visible control
    logic       enable_ff;
    logic       range_ff;
    logic [2:0] trim_ff;
    // measurement state
    logic       valid_ff;
    logic       result_ff;
    logic       result_q_ff;
    // interrupt state
    logic [7:0] irq_stat_ff;
    logic [7:0] irq_mask_ff;
    logic       irq_ff;
    logic       pending;
    // output stages
    logic [7:0] rdata_ff;
    logic       power_ff;
    // internal strobes
    logic       settle_run;
    logic       settle_done;
    logic       dip_seen;
    logic       rise;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_irqs;
    logic       wr_irqm;

    // write decode
    assign wr_ctrl = reg_wr && hit(reg_addr, sld_pkg::CTRL_OFF);
    assign wr_stat = reg_wr && hit(reg_addr, sld_pkg::STAT_OFF);
    assign wr_irqs = reg_wr && hit(reg_addr, sld_pkg::IRQS_OFF);
    assign wr_irqm = reg_wr && hit(reg_addr, sld_pkg::IRQM_OFF);

    // range select; upper control bits are reserved and read 0
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            range_ff <= sld_pkg::CTRL_RST[sld_pkg::RANGE_BIT];
        end else if (wr_ctrl) begin
            range_ff <= reg_wdata[sld_pkg::RANGE_BIT];
        end
    end

    // trim is stored only; production writes it once per unit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            trim_ff <= sld_pkg::CTRL_RST[sld_pkg::TRIM_LSB +: sld_pkg::TRIM_W];
        end else if (wr_ctrl) begin
            trim_ff <= reg_wdata[sld_pkg::TRIM_LSB +: sld_pkg::TRIM_W];
        end
    end

    // enable is the only writable status bit
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enable_ff <= sld_pkg::STAT_RST[sld_pkg::EN_BIT];
        end else if (wr_stat) begin
            enable_ff <= reg_wdata[sld_pkg::EN_BIT];
        end
    end

    // detector sequence: off, settling, active
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sld_pkg::ST_OFF: begin
                if (enable_ff) begin
                    nxt_state = sld_pkg::ST_SETTLE;
                end
            end
            sld_pkg::ST_SETTLE: begin
                if (!enable_ff) begin
                    nxt_state = sld_pkg::ST_OFF;
                end else if (settle_done) begin
                    nxt_state = sld_pkg::ST_ACTIVE;
                end
            end
            sld_pkg::ST_ACTIVE: begin
                if (!enable_ff) begin
                    nxt_state = sld_pkg::ST_OFF;
                end
            end
            default: begin
                nxt_state = sld_pkg::ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= sld_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // timer runs only while settling, so a disable restarts it from zero
    assign settle_run = (state_ff == sld_pkg::ST_SETTLE);

    // settling time counts from the enable, restarts after any disable
    sld_settle_timer #(
        .COUNT (SETTLE_CYC)
    ) u_settle (
        .clock   (clock),
        .sys_rst (sys_rst),
        .run     (settle_run),
        .done_ff (settle_done)
    );

    // comparator only trusted while powered; brief dips filtered out
    sld_pulse_filter #(
        .COUNT (PULSE_CYC)
    ) u_filter (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .enable    (power_ff),
        .sample    (comp_below),
        .stable_ff (dip_seen)
    );

    // analog power follows enable; no current drawn while off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            power_ff <= 1'b0;
        end else begin
            power_ff <= enable_ff;
        end
    end

    // valid flag, dropped at once when disabled
    always_ff @(posedge clock) begin
        if (sys_rst || !enable_ff) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= (state_ff == sld_pkg::ST_ACTIVE);
        end
    end

    // result held low until valid so no early edge fires
    always_ff @(posedge clock) begin
        if (sys_rst || !enable_ff) begin
            result_ff <= 1'b0;
        end else begin
            result_ff <= valid_ff && dip_seen;
        end
    end

    // edge detect on the result
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            result_q_ff <= 1'b0;
        end else begin
            result_q_ff <= result_ff;
        end
    end

    assign rise = result_ff && !result_q_ff;

    // per-bit sticky status and mask; only the detector source exists,
    // the other positions stay zero so one clear routine fits all
    for (genvar b = 0; b < 8; b++) begin : g_irq
        if (b == sld_pkg::IRQ_BIT) begin : g_src
            // write one to clear; a new edge beats the clear
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    irq_stat_ff[b] <= sld_pkg::IRQ_RST[b];
                end else if (rise) begin
                    irq_stat_ff[b] <= 1'b1;
                end else if (wr_irqs && reg_wdata[b]) begin
                    irq_stat_ff[b] <= 1'b0;
                end
            end

            // mask bit, owned by software
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    irq_mask_ff[b] <= sld_pkg::IRQ_RST[b];
                end else if (wr_irqm) begin
                    irq_mask_ff[b] <= reg_wdata[b];
                end
            end
        end else begin : g_none
            // unbuilt sources: constant zero, writes ignored
            assign irq_stat_ff[b] = 1'b0;
            assign irq_mask_ff[b] = 1'b0;
        end
    end

    // any unmasked event still pending
    assign pending = |(irq_stat_ff & irq_mask_ff);

    // level interrupt, high while an unmasked bit is set
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= pending;
        end
    end

    // register read decode, unmapped indices read zero
    function automatic logic [7:0] read_word(
        input logic [3:0] a,
        input logic [7:0] ctrl,
        input logic [7:0] stat,
        input logic [7:0] irqs,
        input logic [7:0] irqm
    );
        if (hit(a, sld_pkg::CTRL_OFF)) begin
            read_word = ctrl;
        end else if (hit(a, sld_pkg::STAT_OFF)) begin
            read_word = stat;
        end else if (hit(a, sld_pkg::IRQS_OFF)) begin
            read_word = irqs;
        end else if (hit(a, sld_pkg::IRQM_OFF)) begin
            read_word = irqm;
        end else begin
            read_word = 8'h00;
        end
    endfunction

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst || !reg_rd) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= read_word(reg_addr,
                                  ctrl_word(range_ff, trim_ff),
                                  stat_word(enable_ff, valid_ff, result_ff),
                                  irq_stat_ff,
                                  irq_mask_ff);
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata         = rdata_ff;
    assign detector_power_en = power_ff;
    assign range_select      = range_ff;
    assign threshold_trim    = trim_ff;
    assign low_supply_irq    = irq_ff;
endmodule
`default_nettype wire

// File: verification/sld_top_asserts.sv
// port-level checker for the supply level detector control
`timescale 1ns/1ps
`default_nettype none
module sld_top_chk #(
    parameter int SETTLE_CYC = 20,
    parameter int PULSE_CYC  = 8
) (
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       comp_below,
    input wire logic       detector_power_en,
    input wire logic       range_select,
    input wire logic [2:0] threshold_trim,
    input wire logic       low_supply_irq
);
    int on_cnt_ff;
    // powered cycles; bounds the valid flag from both sides
    always_ff @(posedge clock) begin
        if (sys_rst || !detector_power_en)
            on_cnt_ff <= 0;
        else
            on_cnt_ff <= on_cnt_ff + 1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence ctrl_wr_s;
        reg_wr && reg_addr == sld_pkg::CTRL_OFF ##1 !reg_wr;
    endsequence
    sequence stat_rd_s;
        reg_rd && reg_addr == sld_pkg::STAT_OFF;
    endsequence
    power_on_a: assert property (reg_wr && reg_addr == sld_pkg::STAT_OFF ##1 !reg_wr
        |-> ##1 detector_power_en == $past(reg_wdata[0], 2)) else $error("power bad");
    ctrl_out_a: assert property (ctrl_wr_s
        |-> ##1 {range_select, threshold_trim} == $past(reg_wdata[3:0], 2)) else $error("ctrl");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata");
    unmapped_a: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rdata == 8'h00) else $error("map");
    ctrl_rsvd_a: assert property (reg_rd && reg_addr == sld_pkg::CTRL_OFF
        |=> reg_rdata[7:4] == 4'h0) else $error("ctrl rsvd");
    stat_bits_a: assert property (stat_rd_s |=> reg_rdata[7:3] == 5'h00
        && (!reg_rdata[2] || reg_rdata[1]) && (!reg_rdata[1] || reg_rdata[0])) else $error("st");
    settle_win_a: assert property (stat_rd_s |=> (!reg_rdata[1] || on_cnt_ff >= SETTLE_CYC - 1)
        && (on_cnt_ff < SETTLE_CYC + 5 || reg_rdata[1])) else $error("settle");
    irq_bit_a: assert property (reg_rd && reg_addr == sld_pkg::IRQS_OFF
        |=> (reg_rdata & 8'hFB) == 8'h00) else $error("irq bit");
    mask_off_a: assert property (reg_wr && reg_addr == sld_pkg::IRQM_OFF && !reg_wdata[2]
        ##1 !reg_wr |-> ##1 !low_supply_irq) else $error("mask");
endmodule
bind sld_top sld_top_chk #(.SETTLE_CYC(SETTLE_CYC), .PULSE_CYC(PULSE_CYC)) i_chk (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_below(comp_below),
    .detector_power_en(detector_power_en), .range_select(range_select),
    .threshold_trim(threshold_trim), .low_supply_irq(low_supply_irq));
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the supply level detector control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int SC = 20;
    localparam int PC = 8;
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic       comp_below = 1'b0;
    logic       detector_power_en;
    logic       range_select;
    logic [2:0] threshold_trim;
    logic       low_supply_irq;
    int         bad_count = 0;
    int         cmp_count = 0;
    // 200 MHz clock, never stopped so detector timings hold
    always #2.5 clock = ~clock;
    // short counts keep the run brief
    sld_top #(.SETTLE_CYC(SC), .PULSE_CYC(PC)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_below(comp_below),
        .detector_power_en(detector_power_en), .range_select(range_select),
        .threshold_trim(threshold_trim), .low_supply_irq(low_supply_irq));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        // step off the edge so levels are looked at once settled
        #1;
    endtask
    task automatic comp(input logic v);
        @(posedge clock);
        comp_below <= v;
    endtask
    task automatic t_ctrl();
        rd(sld_pkg::CTRL_OFF, 8'h00);
        rd(sld_pkg::STAT_OFF, 8'h00);
        wr(sld_pkg::CTRL_OFF, 8'hFF);
        rd(sld_pkg::CTRL_OFF, 8'h0F);
        chk(8'({range_select, threshold_trim}), 8'h0F);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
    endtask
    // enable alone starts settling; read-only bits ignore writes
    task automatic t_settle();
        wr(sld_pkg::STAT_OFF, 8'h07);
        rd(sld_pkg::STAT_OFF, 8'h01);
        chk(8'(detector_power_en), 8'h01);
        idle(SC - 5);
        rd(sld_pkg::STAT_OFF, 8'h01);
        idle(4);
        rd(sld_pkg::STAT_OFF, 8'h03);
    endtask
    task automatic t_irq();
        wr(sld_pkg::IRQM_OFF, 8'hFF);
        rd(sld_pkg::IRQM_OFF, 8'h04);
        comp(1'b1);
        idle(PC + 6);
        rd(sld_pkg::STAT_OFF, 8'h07);
        rd(sld_pkg::IRQS_OFF, 8'h04);
        chk(8'(low_supply_irq), 8'h01);
        wr(sld_pkg::IRQS_OFF, 8'h04);
        idle(2);
        chk(8'(low_supply_irq), 8'h00);
        comp(1'b0);
        idle(3);
        rd(sld_pkg::STAT_OFF, 8'h03);
        comp(1'b1);
        idle(PC - 4);
        comp(1'b0);
        idle(PC + 4);
        rd(sld_pkg::IRQS_OFF, 8'h00);
        comp(1'b1);
        idle(PC + 6);
        rd(sld_pkg::IRQS_OFF, 8'h04);
        wr(sld_pkg::IRQM_OFF, 8'h00);
        idle(2);
        chk(8'(low_supply_irq), 8'h00);
    endtask
    // comparator stays low-supply: result must wait for new settling
    task automatic t_off();
        wr(sld_pkg::STAT_OFF, 8'h00);
        rd(sld_pkg::STAT_OFF, 8'h00);
        chk(8'(detector_power_en), 8'h00);
        wr(sld_pkg::STAT_OFF, 8'h01);
        idle(SC - 5);
        rd(sld_pkg::STAT_OFF, 8'h01);
    endtask
    // reset in mid-run returns control, status, irq status, power and irq output to zero
    task automatic t_rst();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(sld_pkg::CTRL_OFF, 8'h00);
        rd(sld_pkg::STAT_OFF, 8'h00);
        rd(sld_pkg::IRQS_OFF, 8'h00);
        chk(8'({detector_power_en, low_supply_irq}), 8'h00);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        t_ctrl();
        t_settle();
        t_irq();
        t_off();
        t_rst();
        print_verdict();
    end
endmodule
`default_nettype wire
